// file: rtl/misc_system_csr_bank.v
// System register bank: timer, host word order, free running ticks, dropped frames, MAC indirect access
//
// Contract
// - Timer run bit 29 starts or halts timer
// - Run bit falling forces preload to FFFFh
// - Preload field bits 15-0, resets FFFFh
// - Timer interval completion raises event
// - Timer present value readable, resets FFFFh
// - Other order: select high reaches upper half
// - All ones order: mapping reversed
// - Link side halfword order stays fixed
// - 32-bit counter at 25MHz, wraps
// - Latch whole count on first halfword
// - Counter runs in every power state
// - Dropped frames counted, cleared on read
// - Event on dropped count reaching midpoint
// - Busy bit launches access, self clears
// - Read data stored before busy clears
// - Direction bit 30: one read, zero write
// - Address bits 7-0 pick MAC register
// - Indirect data 32-bit, resets zero
`timescale 1ns/10ps
`include "misc_csr_defs.vh"
module misc_system_csr_bank #(
   parameter TICK_DIV = `TIMER_TICK_NS / `CLK_PERIOD_NS   // Clock cycles per timer tick
) (
   input  wire        CLK_IN,            // 10 MHz system clock
   input  wire        SYS_RST_IN,        // Asynchronous reset, active high
   input  wire [7:1]  ADDR_IN,           // Host address, bit 1 is the halfword select
   input  wire        CS_N_IN,           // Host chip select, active low
   input  wire        RD_N_IN,           // Host read strobe, active low
   input  wire        WR_N_IN,           // Host write strobe, active low
   input  wire [15:0] DATA_IN,           // Host write data
   output reg  [15:0] DATA_OUT,          // Host read data
   output reg         DATA_OE_OUT,       // High while the bank drives the data bus
   input  wire        FRAME_DROPPED_IN,  // One-cycle pulse per discarded receive frame
   output reg         TIMER_EVENT_OUT,   // One-cycle pulse at each timer interval end
   output reg         DROP_HALF_EVENT_OUT, // One-cycle pulse when dropped count reaches midpoint
   output wire        MAC_REQ_OUT,       // Indirect request to MAC register space
   output wire        MAC_READ_OUT,      // Request direction, high for read
   output wire [7:0]  MAC_ADDR_OUT,      // Request address
   output wire [31:0] MAC_WDATA_OUT,     // Request write data
   input  wire        MAC_ACK_IN,        // Acknowledge from MAC side
   input  wire [31:0] MAC_RDATA_IN       // Read data valid with acknowledge
);
   // Host pin synchronisers, first stage read only by the second
   reg  [6:0]  addr_s1_reg;              // Address, first stage
   reg  [6:0]  addr_s2_reg;              // Address, second stage
   reg  [15:0] wdat_s1_reg;              // Write data, first stage
   reg  [15:0] wdat_s2_reg;              // Write data, second stage
   reg  [2:0]  strb_s1_reg;              // {cs_n, rd_n, wr_n}, first stage
   reg  [2:0]  strb_s2_reg;              // {cs_n, rd_n, wr_n}, second stage
   reg         rd_act_reg;               // Read active in the last cycle
   reg         wr_act_reg;               // Write active in the last cycle

   wire        rd_act  = ~strb_s2_reg[2] & ~strb_s2_reg[1];
   wire        wr_act  = ~strb_s2_reg[2] & ~strb_s2_reg[0];
   wire        rd_start = rd_act & ~rd_act_reg;      // Read taken at strobe start
   wire        wr_end   = ~wr_act & wr_act_reg;      // Write taken at strobe end, data settled

   // Register state
   reg         timer_run_reg;            // Timer run control
   reg  [15:0] timer_preload_reg;        // Reload value
   reg  [15:0] timer_present_value_reg;  // Present count
   reg  [31:0] host_word_order_reg;      // Halfword order control
   reg  [31:0] tick_count_reg;           // Free running 25 MHz count
   reg         tick_phase_reg;           // Alternates the 2 and 3 step
   reg  [15:0] tick_snap_reg;            // Upper half caught with the first read
   reg  [31:0] dropped_frames_reg;       // Dropped frame count
   reg  [15:0] drop_snap_reg;            // Upper half caught with the first read
   reg         ind_dir_reg;              // Indirect direction, one is read
   reg  [7:0]  ind_addr_reg;             // Indirect MAC register address
   reg  [31:0] mac_indirect_data_reg;    // Indirect data

   wire        timer_tick;               // Fixed internal timer tick
   wire        ind_busy;                 // Indirect access in flight
   wire        ind_done_read;            // Read completion
   wire [31:0] ind_rdata;                // Returned read data
   reg         ind_start;                // Launch pulse

   // Address decode: byte offset and which 16-bit half of the register is reached
   wire [7:0]  offset = {addr_s2_reg[6:1], 2'b00};
   wire        swapped = (host_word_order_reg == `WORD_ORDER_SWAP);
   wire        upper  = addr_s2_reg[0] ^ swapped;
   // The order setting only steers host halves; FIFO to link ordering lives elsewhere
   // and always puts the low halfword first on the wire

   wire        wr_hit = wr_end;
   wire        rd_hit = rd_start;
   // Lower-half drop read snapshots and clears
   wire        drop_clear = rd_hit && !upper && (offset == `OFS_DROPPED_FRAMES);

   // Select one half of a 32-bit value
   function [15:0] half_of;
      input [31:0] value;
      input        hi;
      begin
         half_of = hi ? value[31:16] : value[15:0];
      end
   endfunction

   // Merge a written halfword into a 32-bit value
   function [31:0] merge_half;
      input [31:0] value;
      input [15:0] data;
      input        hi;
      begin
         merge_half = hi ? {data, value[15:0]} : {value[31:16], data};
      end
   endfunction

   // Fixed timer tick from the clock divider
   tick_divider #(
      .DIV      (TICK_DIV)
   ) timer_tick_gen (
      .clk_in   (CLK_IN),
      .rst_in   (SYS_RST_IN),
      .tick_out (timer_tick)
   );

   // Indirect MAC register access sequencer
   // Direction from the launching write; the stored copy lands an edge late
   mac_indirect_port ind_port (
      .clk_in        (CLK_IN),
      .rst_in        (SYS_RST_IN),
      .start_in      (ind_start),
      .dir_read_in   (wdat_s2_reg[`IND_DIR_HBIT]),
      .addr_in       (ind_addr_reg),
      .wdata_in      (mac_indirect_data_reg),
      .busy_out      (ind_busy),
      .done_out      (),
      .done_read_out (ind_done_read),
      .rdata_out     (ind_rdata),
      .mac_req_out   (MAC_REQ_OUT),
      .mac_read_out  (MAC_READ_OUT),
      .mac_addr_out  (MAC_ADDR_OUT),
      .mac_wdata_out (MAC_WDATA_OUT),
      .mac_ack_in    (MAC_ACK_IN),
      .mac_rdata_in  (MAC_RDATA_IN)
   );

   // Host pins pass two flops; strobe activity is remembered for edge finding
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         addr_s1_reg <= 7'h00;
         addr_s2_reg <= 7'h00;
         wdat_s1_reg <= 16'h0000;
         wdat_s2_reg <= 16'h0000;
         // Idle strobe levels, so no false edge after reset
         strb_s1_reg <= 3'h7;
         strb_s2_reg <= 3'h7;
         rd_act_reg  <= 1'b0;
         wr_act_reg  <= 1'b0;
      end else begin
         addr_s1_reg <= ADDR_IN;
         addr_s2_reg <= addr_s1_reg;
         wdat_s1_reg <= DATA_IN;
         wdat_s2_reg <= wdat_s1_reg;
         strb_s1_reg <= {CS_N_IN, RD_N_IN, WR_N_IN};
         strb_s2_reg <= strb_s1_reg;
         rd_act_reg  <= rd_act;
         wr_act_reg  <= wr_act;
      end
   end

   // Busy bit write launches an access; ignored while one is already running
   always @* begin
      ind_start = wr_hit && upper && (offset == `OFS_MAC_IND_COMMAND) &&
                  wdat_s2_reg[`IND_BUSY_HBIT] && !ind_busy;
   end

   // Timer: run control, preload and the down counter
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         timer_run_reg           <= 1'b0;
         timer_preload_reg       <= `PRELOAD_RESET;
         timer_present_value_reg <= `COUNT_RESET;
         TIMER_EVENT_OUT         <= 1'b0;
      end else begin
         TIMER_EVENT_OUT <= 1'b0;
         // A config write beats a tick in the same cycle
         if (wr_hit && (offset == `OFS_TIMER_CONFIG) && upper) begin
            timer_run_reg <= wdat_s2_reg[`TIMER_RUN_HBIT];
            if (!wdat_s2_reg[`TIMER_RUN_HBIT] && timer_run_reg)
               timer_preload_reg <= `PRELOAD_RESET;                        // Falling run bit
            else if (wdat_s2_reg[`TIMER_RUN_HBIT] && !timer_run_reg)
               timer_present_value_reg <= timer_preload_reg;               // Start from preload
         end else if (wr_hit && (offset == `OFS_TIMER_CONFIG)) begin
            timer_preload_reg <= wdat_s2_reg;
         end else if (timer_run_reg && timer_tick) begin
            if (timer_present_value_reg == `HALF_ZERO) begin
               timer_present_value_reg <= timer_preload_reg;               // Reload at zero
               TIMER_EVENT_OUT         <= 1'b1;                            // Interval done
            end else begin
               timer_present_value_reg <= timer_present_value_reg - 16'h0001;
            end
         end
      end
   end

   // Halfword order control, plain read and write
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN)
         host_word_order_reg <= `WORD_ORDER_RESET;
      else if (wr_hit && (offset == `OFS_HOST_WORD_ORDER))
         host_word_order_reg <= merge_half(host_word_order_reg, wdat_s2_reg, upper);
   end

   // Free running count: steps 2 and 3 in turn, 25 per microsecond; no gating by any power state
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         tick_count_reg <= 32'h0000_0000;
         tick_phase_reg <= 1'b0;
      end else begin
         tick_phase_reg <= ~tick_phase_reg;
         tick_count_reg <= tick_count_reg +
                           (tick_phase_reg ? `TICKS_STEP_HIGH : `TICKS_STEP_LOW);   // Wraps
      end
   end

   // Dropped frames: a drop in the same cycle as the clearing read is kept
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         dropped_frames_reg  <= `DROP_RESET;
         DROP_HALF_EVENT_OUT <= 1'b0;
      end else begin
         // No midpoint event when a clearing read meets the drop
         DROP_HALF_EVENT_OUT <= FRAME_DROPPED_IN && !drop_clear &&
                                (dropped_frames_reg + 32'h0000_0001 == `DROP_MIDPOINT);
         if (drop_clear)
            dropped_frames_reg <= FRAME_DROPPED_IN ? 32'h0000_0001 : `DROP_RESET;
         else if (FRAME_DROPPED_IN)
            dropped_frames_reg <= dropped_frames_reg + 32'h0000_0001;
      end
   end

   // Snapshots: the lower-half read catches the upper half of the same sample
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         tick_snap_reg <= 16'h0000;
         drop_snap_reg <= 16'h0000;
      end else if (rd_hit && !upper) begin
         if (offset == `OFS_FREE_RUN_TICKS)
            tick_snap_reg <= tick_count_reg[31:16];
         if (offset == `OFS_DROPPED_FRAMES)
            drop_snap_reg <= dropped_frames_reg[31:16];
      end
   end

   // Indirect command and data; host writes are dropped while busy as a guard
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         ind_dir_reg           <= 1'b0;
         ind_addr_reg          <= 8'h00;
         mac_indirect_data_reg <= `IND_DATA_RESET;
      end else if (ind_done_read) begin
         mac_indirect_data_reg <= ind_rdata;                               // Lands as busy clears
      // Host writes while busy are refused, not queued
      end else if (wr_hit && !ind_busy) begin
         if (offset == `OFS_MAC_IND_COMMAND && upper)
            ind_dir_reg <= wdat_s2_reg[`IND_DIR_HBIT];
         else if (offset == `OFS_MAC_IND_COMMAND)
            ind_addr_reg <= wdat_s2_reg[`IND_ADDR_MSB:`IND_ADDR_LSB];
         else if (offset == `OFS_MAC_IND_DATA)
            mac_indirect_data_reg <= merge_half(mac_indirect_data_reg, wdat_s2_reg, upper);
      end
   end

   // Read data: loaded at strobe start, held until the next read; unmapped reads zero
   always @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         DATA_OUT    <= 16'h0000;
         DATA_OE_OUT <= 1'b0;
      end else begin
         DATA_OE_OUT <= rd_act;
         if (rd_hit) begin
            case (offset)
               `OFS_TIMER_CONFIG:
                  DATA_OUT <= upper ? {2'b00, timer_run_reg, 13'h0000} : timer_preload_reg;
               `OFS_TIMER_COUNT:
                  DATA_OUT <= upper ? 16'h0000 : timer_present_value_reg;
               `OFS_HOST_WORD_ORDER:
                  DATA_OUT <= half_of(host_word_order_reg, upper);
               `OFS_FREE_RUN_TICKS:
                  DATA_OUT <= upper ? tick_snap_reg : tick_count_reg[15:0];
               `OFS_DROPPED_FRAMES:
                  DATA_OUT <= upper ? drop_snap_reg : dropped_frames_reg[15:0];
               `OFS_MAC_IND_COMMAND:
                  DATA_OUT <= upper ? {ind_busy, ind_dir_reg, 14'h0000} : {8'h00, ind_addr_reg};
               `OFS_MAC_IND_DATA:
                  DATA_OUT <= half_of(mac_indirect_data_reg, upper);
               default:
                  DATA_OUT <= 16'h0000;
            endcase
         end
      end
   end
endmodule

// file: rtl/misc_csr_defs.vh
// Register offsets, field positions, reset values and timing figures for the system register bank
`ifndef MISC_CSR_DEFS_VH
`define MISC_CSR_DEFS_VH

// Byte offsets of the registers on the host bus
`define OFS_TIMER_CONFIG     8'h8C
`define OFS_TIMER_COUNT      8'h90
`define OFS_HOST_WORD_ORDER  8'h98
`define OFS_FREE_RUN_TICKS   8'h9C
`define OFS_DROPPED_FRAMES   8'hA0
`define OFS_MAC_IND_COMMAND  8'hA4
`define OFS_MAC_IND_DATA     8'hA8

// Field positions inside a halfword (bit number minus 16 for the upper-half fields, address bits in the lower half)
`define TIMER_RUN_HBIT       4'hD
`define IND_BUSY_HBIT        4'hF
`define IND_DIR_HBIT         4'hE
`define IND_ADDR_MSB         7
`define IND_ADDR_LSB         0

// Reset and forced values
`define PRELOAD_RESET        16'hFFFF
`define COUNT_RESET          16'hFFFF
`define WORD_ORDER_RESET     32'h0000_0000
`define WORD_ORDER_SWAP      32'hFFFF_FFFF
`define DROP_RESET           32'h0000_0000
`define DROP_MIDPOINT        32'h8000_0000
`define IND_DATA_RESET       32'h0000_0000
`define HALF_ZERO            16'h0000

// Free running counter advances 2 then 3 per 100 ns clock, 25 counts per microsecond
`define TICKS_STEP_LOW       32'h0000_0002
`define TICKS_STEP_HIGH      32'h0000_0003

// Clock period and the timer tick period, both in ns
`define CLK_PERIOD_NS        100
`define TIMER_TICK_NS        1000

`endif

// file: rtl/tick_divider.v
// One-cycle enable pulse generator dividing the system clock
`timescale 1ns/10ps
module tick_divider #(
   parameter DIV = 10                    // Clock cycles per pulse
) (
   input  wire clk_in,                   // System clock
   input  wire rst_in,                   // Asynchronous reset, active high
   output reg  tick_out                  // One-cycle enable pulse
);
   reg [15:0] count_reg;                 // Cycles since the last pulse

   // Count up and emit a pulse on the last cycle of each period
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_reg <= 16'h0000;
         tick_out  <= 1'b0;
      end else if (count_reg == DIV[15:0] - 16'h0001) begin
         count_reg <= 16'h0000;
         tick_out  <= 1'b1;
      end else begin
         count_reg <= count_reg + 16'h0001;
         tick_out  <= 1'b0;
      end
   end
endmodule

// file: rtl/mac_indirect_port.v
// Sequencer for one indirect access to the internal MAC register space
`timescale 1ns/10ps
module mac_indirect_port (
   input  wire        clk_in,            // System clock
   input  wire        rst_in,            // Asynchronous reset, active high
   input  wire        start_in,          // Launch pulse from the busy bit write
   input  wire        dir_read_in,       // One asks for a read, zero a write
   input  wire [7:0]  addr_in,           // Selected MAC register
   input  wire [31:0] wdata_in,          // Value for a write
   output wire        busy_out,          // Access in flight
   output wire        done_out,          // Completion, same edge as busy falls
   output wire        done_read_out,     // Completion of a read
   output wire [31:0] rdata_out,         // Returned value, valid with done_out
   output wire        mac_req_out,       // Request held until acknowledged
   output reg         mac_read_out,      // Direction of the request
   output reg  [7:0]  mac_addr_out,      // Address of the request
   output reg  [31:0] mac_wdata_out,     // Write data of the request
   input  wire        mac_ack_in,        // Acknowledge from MAC side logic
   input  wire [31:0] mac_rdata_in       // Read data valid with acknowledge
);
   localparam ST_IDLE = 2'b01;           // Waiting for a launch
   localparam ST_REQ  = 2'b10;           // Request outstanding

   reg [1:0] state_reg;                  // One-hot state
   reg [1:0] state_next;                 // Next state

   assign busy_out      = state_reg[1];
   assign mac_req_out   = state_reg[1];
   assign done_out      = state_reg[1] & mac_ack_in;   // Lets the data land as busy drops
   assign done_read_out = done_out & mac_read_out;
   assign rdata_out     = mac_rdata_in;

   // Next state: the request stays up until acknowledged
   always @* begin
      case (state_reg)
         ST_IDLE: state_next = start_in ? ST_REQ : ST_IDLE;
         ST_REQ:  state_next = mac_ack_in ? ST_IDLE : ST_REQ;   // Busy clears itself
         default: state_next = ST_IDLE;
      endcase
   end

   // State and request fields, captured once at launch
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg     <= ST_IDLE;
         mac_read_out  <= 1'b0;
         mac_addr_out  <= 8'h00;
         mac_wdata_out <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         if (state_reg[0] && start_in) begin
            mac_read_out  <= dir_read_in;
            mac_addr_out  <= addr_in;
            mac_wdata_out <= wdata_in;
         end
      end
   end
endmodule

// file: test/misc_csr_assertions.sv
// Port-level checker for the system register bank
`timescale 1ns/10ps
module misc_csr_checker #(
   parameter TICK_DIV = 10                // Clock cycles per timer tick
) (
   input wire        CLK_IN,
   input wire        SYS_RST_IN,
   input wire [7:1]  ADDR_IN,
   input wire        CS_N_IN,
   input wire        RD_N_IN,
   input wire        WR_N_IN,
   input wire [15:0] DATA_IN,
   input wire [15:0] DATA_OUT,
   input wire        DATA_OE_OUT,
   input wire        FRAME_DROPPED_IN,
   input wire        TIMER_EVENT_OUT,
   input wire        DROP_HALF_EVENT_OUT,
   input wire        MAC_REQ_OUT,
   input wire        MAC_READ_OUT,
   input wire [7:0]  MAC_ADDR_OUT,
   input wire [31:0] MAC_WDATA_OUT,
   input wire        MAC_ACK_IN,
   input wire [31:0] MAC_RDATA_IN
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // Request still open, and request being answered
   sequence s_wait; MAC_REQ_OUT && !MAC_ACK_IN; endsequence
   sequence s_ack; MAC_REQ_OUT && MAC_ACK_IN; endsequence
   sequence s_launch; $rose(MAC_REQ_OUT); endsequence
   chk_req_holds: assert property (s_wait |=> MAC_REQ_OUT)
      else $error("request dropped before acknowledge");
   chk_req_ends: assert property (s_ack |=> !MAC_REQ_OUT)
      else $error("request kept after acknowledge");
   chk_req_stable: assert property (s_wait |=> $stable(MAC_ADDR_OUT) && $stable(MAC_WDATA_OUT))
      else $error("request fields moved while waiting");
   // Launch only comes from a busy write to the command upper half
   chk_launch_src: assert property (s_launch |-> $past(ADDR_IN, 3) == 7'h53 && $past(DATA_IN[15], 3))
      else $error("request without busy write");
   chk_launch_dir: assert property (s_launch |-> MAC_READ_OUT == $past(DATA_IN[14], 3))
      else $error("request direction wrong");
   chk_oe_cause: assert property ($rose(DATA_OE_OUT) |-> $past(RD_N_IN, 2) == 1'b0 && $past(CS_N_IN, 2) == 1'b0)
      else $error("bus driven without read");
   chk_oe_release: assert property (RD_N_IN [*6] |-> !DATA_OE_OUT)
      else $error("bus still driven after read");
   chk_timer_pulse: assert property (TIMER_EVENT_OUT && TICK_DIV > 1 |=> !TIMER_EVENT_OUT)
      else $error("timer event longer than a cycle");
   chk_drop_event: assert property (DROP_HALF_EVENT_OUT |-> $past(FRAME_DROPPED_IN) ##1 !DROP_HALF_EVENT_OUT)
      else $error("midpoint event without drop");
endmodule
bind misc_system_csr_bank misc_csr_checker #(.TICK_DIV(TICK_DIV)) chk_i (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
   .ADDR_IN(ADDR_IN), .CS_N_IN(CS_N_IN), .RD_N_IN(RD_N_IN), .WR_N_IN(WR_N_IN), .DATA_IN(DATA_IN),
   .DATA_OUT(DATA_OUT), .DATA_OE_OUT(DATA_OE_OUT), .FRAME_DROPPED_IN(FRAME_DROPPED_IN),
   .TIMER_EVENT_OUT(TIMER_EVENT_OUT), .DROP_HALF_EVENT_OUT(DROP_HALF_EVENT_OUT), .MAC_REQ_OUT(MAC_REQ_OUT),
   .MAC_READ_OUT(MAC_READ_OUT), .MAC_ADDR_OUT(MAC_ADDR_OUT), .MAC_WDATA_OUT(MAC_WDATA_OUT),
   .MAC_ACK_IN(MAC_ACK_IN), .MAC_RDATA_IN(MAC_RDATA_IN));

// file: test/mac_side_model.sv
// Behavioural MAC side register responder for indirect requests
`timescale 1ns/10ps
module mac_side_model (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire [3:0]  delay_in,           // Cycles before the answer
   input  wire        req_in,
   input  wire        read_in,
   input  wire [7:0]  addr_in,
   output reg         ack_out,
   output wire [31:0] rdata_out
);
   reg [3:0]  wait_reg;                   // Cycles spent on this request
   reg [31:0] value_reg;                  // Value sent with the answer
   // Data only valid with ack; inverted otherwise so a stale capture shows
   assign rdata_out = ack_out ? value_reg : ~value_reg;
   // One-cycle answer once the delay has passed
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_out   <= 1'b0;
         wait_reg  <= 4'h0;
         value_reg <= 32'h0000_0000;
      end else if (req_in && !ack_out && wait_reg >= delay_in) begin
         ack_out   <= 1'b1;
         value_reg <= read_in ? {24'hC3A5_96, addr_in} : 32'h0000_0000;
      end else begin
         ack_out  <= 1'b0;
         wait_reg <= (req_in && !ack_out) ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule

// file: test/misc_system_csr_bank_tb.sv
// Self-checking bench for the system register bank
`timescale 1ns/10ps
module misc_system_csr_bank_tb;
   reg         clk, rst, cs_n, rd_n, wr_n, drop;
   reg  [7:1]  addr;
   reg  [15:0] wdata, v, w;
   reg  [31:0] x;
   reg  [3:0]  mdelay;                    // Answer delay of the MAC side
   wire [15:0] rdata;
   wire [31:0] mwdata, mrdata;
   wire [7:0]  maddr;
   wire        oe, tev, dev, mreq, mrd, mack;
   integer     error_cnt, samples_checked, n;
   misc_system_csr_bank #(.TICK_DIV(2)) uut (.CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .CS_N_IN(cs_n),
      .RD_N_IN(rd_n), .WR_N_IN(wr_n), .DATA_IN(wdata), .DATA_OUT(rdata), .DATA_OE_OUT(oe),
      .FRAME_DROPPED_IN(drop), .TIMER_EVENT_OUT(tev), .DROP_HALF_EVENT_OUT(dev), .MAC_REQ_OUT(mreq),
      .MAC_READ_OUT(mrd), .MAC_ADDR_OUT(maddr), .MAC_WDATA_OUT(mwdata), .MAC_ACK_IN(mack), .MAC_RDATA_IN(mrdata));
   mac_side_model mac (.clk_in(clk), .rst_in(rst), .delay_in(mdelay), .req_in(mreq), .read_in(mrd),
      .addr_in(maddr), .ack_out(mack), .rdata_out(mrdata));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Strobes pass two sync stages
   task hw(input [7:0] ofs, input hi, input [15:0] d);
      begin
         addr <= {ofs[7:2], hi};
         wdata <= d;
         cs_n <= 1'b0;
         wr_n <= 1'b0;
         repeat (4) @(posedge clk);
         cs_n <= 1'b1;
         wr_n <= 1'b1;
         repeat (6) @(posedge clk);
      end
   endtask
   task hr(input [7:0] ofs, input hi, output [15:0] d);
      begin
         addr <= {ofs[7:2], hi};
         cs_n <= 1'b0;
         rd_n <= 1'b0;
         repeat (6) @(posedge clk);
         d = rdata;
         chk(oe, 1'b1);
         cs_n <= 1'b1;
         rd_n <= 1'b1;
         repeat (6) @(posedge clk);
      end
   endtask
   task rd32(input [7:0] ofs, output [31:0] d);
      begin
         hr(ofs, 1'b0, d[15:0]);
         hr(ofs, 1'b1, d[31:16]);
      end
   endtask
   task t_reset;
      begin
         rd32(8'h8C, x); chk(x, 32'h0000_FFFF);
         hw(8'h90, 1'b0, 16'h1234);       // Read-only, must be ignored
         rd32(8'h90, x); chk(x, 32'h0000_FFFF);
         rd32(8'hA0, x); chk(x, 32'h0000_0000);
         rd32(8'hA4, x); chk(x, 32'h0000_0000);
         rd32(8'hA8, x); chk(x, 32'h0000_0000);
         rd32(8'h80, x); chk(x, 32'h0000_0000);
         $display("reset values test done");
      end
   endtask
   // 12 cycles between reads give 30 counts
   task t_ticks;
      begin
         hr(8'h9C, 1'b0, v);
         hr(8'h9C, 1'b0, w);
         chk({16'h0000, w - v}, 32'h0000_001E);
         repeat (27000) @(posedge clk);
         hr(8'h9C, 1'b1, v); chk(v, 16'h0000);
         rd32(8'h9C, x); chk(x[31:16], 16'h0001);
         $display("free running test done");
      end
   endtask
   // Preload 3, tick of 2: event every 8 clocks
   task t_timer;
      begin
         hw(8'h8C, 1'b0, 16'h0003);
         hw(8'h8C, 1'b1, 16'h2000);
         n = 0;
         while (tev !== 1'b1 && n < 100) begin
            @(posedge clk);
            n = n + 1;
         end
         @(posedge clk);
         n = 1;
         while (tev !== 1'b1 && n < 100) begin
            @(posedge clk);
            n = n + 1;
         end
         chk(n, (3 + 1) * 2);
         hr(8'h8C, 1'b0, v); chk(v, 16'h0003);
         hw(8'h8C, 1'b1, 16'h0000);
         hr(8'h90, 1'b0, v);
         hr(8'h90, 1'b0, w); chk(w, v);
         hr(8'h8C, 1'b0, v); chk(v, 16'hFFFF);
         $display("timer test done");
      end
   endtask
   task t_order;
      begin
         hw(8'h98, 1'b0, 16'hFFFF);
         hw(8'h98, 1'b1, 16'hFFFF);
         hr(8'h8C, 1'b1, v); chk(v, 16'hFFFF);
         hr(8'h8C, 1'b0, v); chk(v, 16'h0000);
         hw(8'h98, 1'b1, 16'h0000);
         hw(8'h98, 1'b1, 16'h0000);
         rd32(8'h98, x); chk(x, 32'h0000_0000);
         $display("word order test done");
      end
   endtask
   task t_drops;
      begin
         repeat (3) begin
            drop <= 1'b1;
            @(posedge clk);
            drop <= 1'b0;
            @(posedge clk);
         end
         chk(dev, 1'b0);
         rd32(8'hA0, x); chk(x, 32'h0000_0003);
         rd32(8'hA0, x); chk(x, 32'h0000_0000);
         $display("dropped frame test done");
      end
   endtask
   task t_mac;
      begin
         mdelay <= 4'h1;
         hw(8'hA8, 1'b0, 16'h5678);
         hw(8'hA8, 1'b1, 16'h1234);
         hw(8'hA4, 1'b0, 16'h005A);
         hw(8'hA4, 1'b1, 16'h8000);
         chk({mrd, maddr}, 9'h05A);
         chk(mwdata, 32'h1234_5678);
         hr(8'hA4, 1'b1, v); chk(v, 16'h0000);
         mdelay <= 4'hF;
         hw(8'hA4, 1'b0, 16'h0033);
         hw(8'hA4, 1'b1, 16'hC000);
         chk(mreq, 1'b1);
         hw(8'hA4, 1'b0, 16'h00EE);       // Refused while busy
         n = 0;
         v = 16'h8000;
         while (v[15] !== 1'b0 && n < 10) begin
            hr(8'hA4, 1'b1, v);
            n = n + 1;
         end
         chk(v, 16'h4000);
         hr(8'hA4, 1'b0, v); chk(v, 16'h0033);
         rd32(8'hA8, x); chk(x, 32'hC3A5_9633);
         $display("indirect access test done");
      end
   endtask
   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
         if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      #(40000 * 100);
      error_cnt = error_cnt + 1;
      test_done;
   end
   initial begin
      error_cnt = 0;
      samples_checked = 0;
      {rst, cs_n, rd_n, wr_n} <= 4'hF;
      {drop, addr, wdata, mdelay} <= 28'h000_0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);        // Three idle cycles after reset; the counters are already clear
      t_reset;
      t_ticks;
      t_timer;
      t_order;
      t_drops;
      t_mac;
      test_done;
   end
endmodule
